// ==== logic/ref_level_calc.sv ====
/*
 Gain reference level: fixed terms plus 10*log10 of twice the filter bandwidth, half-dB.
 Assumes the bandwidth input is in Hz and held steady for a few cycles.
*/
`timescale 1ns/1ps
module ref_level_calc #(
   parameter int BW_W = 20
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [BW_W-1:0] bw_in,
   output logic signed [9:0] ref_out
);

   logic [BW_W:0] dbl;
   logic [4:0] msb;
   logic [1:0] frac;
   logic [7:0] log_hd;
   logic [7:0] frac_hd;

   assign dbl = {bw_in, 1'b0};

   // Leading one gives whole octaves, two bits below it a coarse fraction
   always_comb begin
      msb = 5'h00;
      frac = 2'h0;
      for (int i = 2; i <= BW_W; i++) begin
         if (dbl[i]) begin
            msb = 5'(i);
            frac = dbl[i-1 -: 2];
         end
      end
      case (frac)
         2'h0: frac_hd = 8'h00;
         2'h1: frac_hd = 8'h02;
         2'h2: frac_hd = 8'h04;
         default: frac_hd = 8'h05;
      endcase
      // 6 half-dB per octave; 0.02 half-dB short per octave, acceptable for a gain reference
      log_hd = 8'(8'(msb) * 8'h06) + frac_hd;
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ref_out <= rx_gain_pkg::REF_BASE_HD;
      end else begin
         ref_out <= rx_gain_pkg::REF_BASE_HD + $signed({2'b00, log_hd}); // [RULE12]
      end
   end

endmodule : ref_level_calc

// ==== logic/rx_gain_control.sv ====
/*
 Receive gain control: LNA step choice, wait/acquire/hold sequence, re-arm, digital gain loop.
 Assumes level samples, bit ticks and FIFO status arrive synchronous to clk_in.
*/
// How it works
// RULE1 - Code 000 automatic, 001-110 fixed steps
// RULE2 - Gain choice resets to automatic
// RULE3 - Wait until two samples exceed floor
// RULE4 - Pick step, hold it, show it
// RULE5 - No re-arm: keep gain for next packet
// RULE6 - Re-arm after FIFO emptied and delay
// RULE7 - Restart command returns to wait
// RULE8 - Host keeps gain or restarts in continuous
// RULE9 - Host acquires during preamble or ones
// RULE10 - Host sets floor to sensitivity
// RULE11 - Correction filter bandwidth while acquiring
// RULE12 - Reference from fixed terms and bandwidth
// RULE13 - Digital gain readjusts every two bits
// RULE14 - Host enables loop with 0x20 or 0x30
// RULE15 - Digital loop same in every mode
// RULE16 - Level measure unusable with digital loop
// RULE17 - Level readable only above floor
// RULE18 - Re-arm delay counts cycles from empty
`timescale 1ns/1ps
module rx_gain_control #(
   parameter int BW_W = 20
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic rx_enable_in,
   input wire logic packet_mode_in,
   input wire logic gain_choice_wr_in,
   input wire logic [2:0] lna_gain_choice_in,
   input wire logic auto_rearm_enable_in,
   input wire logic [15:0] rearm_delay_in,
   input wire logic receive_rearm_cmd_in,
   input wire logic fifo_empty_in,
   input wire rx_gain_pkg::level_sample_t sample_in,
   input wire logic signed [9:0] signal_floor_in,
   input wire logic afc_auto_in,
   input wire logic [BW_W-1:0] channel_filter_bw_in,
   input wire logic [BW_W-1:0] freq_correction_filter_bw_in,
   input wire logic [7:0] digital_gain_cfg_in,
   input wire logic bit_tick_in,
   input wire logic [7:0] amplitude_in,
   input wire logic level_measure_cmd_in,
   output logic [2:0] lna_gain_choice_out,
   output logic [2:0] applied_lna_step_out,
   output logic agc_waiting_out,
   output logic signed [9:0] signal_level_out,
   output logic level_measure_flag_out,
   output logic [5:0] digital_gain_out,
   output logic filter_bw_sel_out,
   output logic signed [9:0] agc_reference_out
);

   rx_gain_pkg::ctl_state_t s_ff;
   rx_gain_pkg::ctl_state_t nxt_s;
   logic signed [9:0] ref_lvl;
   logic [BW_W-1:0] bw_sel;
   logic [rx_gain_pkg::AGC_THRESHOLDS-1:0] above_th;
   logic above_floor;
   logic dgain_en;
   logic auto_mode;
   logic [2:0] acq_step;

   ////////////////////////////////////////////////////////////////////////////
   // Reference level and thresholds

   assign bw_sel = s_ff.bw_afc ? freq_correction_filter_bw_in : channel_filter_bw_in; // [RULE11]

   ref_level_calc #(
      .BW_W(BW_W)
   ) u_ref (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .bw_in(bw_sel),
      .ref_out(ref_lvl)
   );

   assign agc_reference_out = ref_lvl;

   for (genvar i = 0; i < rx_gain_pkg::AGC_THRESHOLDS; i++) begin : g_thr
      assign above_th[i] = $signed({sample_in.level[9], sample_in.level}) >
         $signed({ref_lvl[9], ref_lvl}) + rx_gain_pkg::AGC_T1_OFS_HD +
         11'(11'(i) * rx_gain_pkg::AGC_T_STEP_HD);
   end

   // Thresholds rise with index, so the count of those passed is the step offset
   always_comb begin
      acq_step = rx_gain_pkg::STEP_MAX_GAIN;
      for (int i = 0; i < rx_gain_pkg::AGC_THRESHOLDS; i++) begin
         acq_step = acq_step + 3'(above_th[i]); // [RULE4]
      end
   end

   assign above_floor = sample_in.valid && (sample_in.level > signal_floor_in);
   assign dgain_en = (digital_gain_cfg_in == rx_gain_pkg::DGAIN_CFG_LOW_INDEX) ||
      (digital_gain_cfg_in == rx_gain_pkg::DGAIN_CFG_NORMAL);
   // Reserved code falls back to automatic control rather than an undefined step
   assign auto_mode = (s_ff.choice == rx_gain_pkg::CHOICE_AUTO) ||
      (s_ff.choice == rx_gain_pkg::CHOICE_RESERVED);

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      nxt_s = s_ff;
      nxt_s.fifo_empty_q = fifo_empty_in;
      if (gain_choice_wr_in) begin
         nxt_s.choice = lna_gain_choice_in;
      end
      case (s_ff.st)
         rx_gain_pkg::ST_IDLE: begin
            nxt_s.hits = 2'h0;
            if (rx_enable_in) begin
               nxt_s.st = rx_gain_pkg::ST_WAIT;
            end
         end
         rx_gain_pkg::ST_WAIT: begin
            if (sample_in.valid) begin
               if (!above_floor) begin
                  nxt_s.hits = 2'h0;
               end else if (s_ff.hits == 2'h1) begin
                  nxt_s.st = rx_gain_pkg::ST_HOLD; // [RULE3]
                  nxt_s.hits = 2'h0;
                  nxt_s.step = acq_step; // [RULE4]
               end else begin
                  nxt_s.hits = 2'h1;
               end
            end
         end
         rx_gain_pkg::ST_HOLD: begin
            // Without re-arm the step simply stays for the next packet [RULE5]
            if (packet_mode_in && auto_rearm_enable_in && fifo_empty_in &&
                !s_ff.fifo_empty_q) begin
               nxt_s.st = rx_gain_pkg::ST_REARM; // [RULE6]
               nxt_s.dly = rearm_delay_in; // [RULE18]
            end
         end
         rx_gain_pkg::ST_REARM: begin
            if (s_ff.dly == 16'h0000) begin
               nxt_s.st = rx_gain_pkg::ST_WAIT; // [RULE6] [RULE18]
            end else begin
               nxt_s.dly = s_ff.dly - 16'h0001;
            end
         end
         default: begin
            nxt_s.st = rx_gain_pkg::ST_IDLE;
         end
      endcase
      if (rx_enable_in && receive_rearm_cmd_in) begin
         nxt_s.st = rx_gain_pkg::ST_WAIT; // [RULE7]
         nxt_s.hits = 2'h0;
      end
      if (!rx_enable_in) begin
         nxt_s.st = rx_gain_pkg::ST_IDLE;
      end
      // Max gain while listening; a fixed choice overrides everything
      if (nxt_s.st == rx_gain_pkg::ST_WAIT && s_ff.st != rx_gain_pkg::ST_WAIT) begin
         nxt_s.step = rx_gain_pkg::STEP_MAX_GAIN;
      end
      if (!auto_mode) begin
         nxt_s.step = s_ff.choice; // [RULE1]
      end
      nxt_s.bw_afc = afc_auto_in && (nxt_s.st == rx_gain_pkg::ST_WAIT); // [RULE11]
      nxt_s.waiting = (nxt_s.st == rx_gain_pkg::ST_WAIT); // [RULE3]

      if (above_floor) begin
         nxt_s.level = sample_in.level; // [RULE17]
      end

      // A new command restarts a measurement; completion needs the following sample
      if (dgain_en) begin
         nxt_s.meas_pend = 1'b0; // [RULE16]
         nxt_s.meas_done = 1'b0;
      end else if (level_measure_cmd_in) begin
         nxt_s.meas_pend = 1'b1;
         // A measurement finishing in the same cycle still reports done
         nxt_s.meas_done = s_ff.meas_pend && sample_in.valid;
      end else if (s_ff.meas_pend && sample_in.valid) begin
         nxt_s.meas_pend = 1'b0;
         nxt_s.meas_done = 1'b1;
      end

      // Mode-independent: only the enable code, bit ticks and amplitude drive it [RULE15]
      if (dgain_en && bit_tick_in) begin
         nxt_s.half = !s_ff.half;
         if (s_ff.half) begin
            if (amplitude_in > rx_gain_pkg::DGAIN_TARGET_AMP && s_ff.dgain != 6'h00) begin
               nxt_s.dgain = s_ff.dgain - 6'h01; // [RULE13]
            end else if (amplitude_in < rx_gain_pkg::DGAIN_TARGET_AMP &&
                         s_ff.dgain != 6'h3f) begin
               nxt_s.dgain = s_ff.dgain + 6'h01; // [RULE13]
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         s_ff <= '{st: rx_gain_pkg::ST_IDLE, choice: rx_gain_pkg::CHOICE_RESET, // [RULE2]
                   hits: 2'h0, step: rx_gain_pkg::STEP_MAX_GAIN,
                   dly: rx_gain_pkg::DELAY_RESET, fifo_empty_q: 1'b1, level: 10'h000,
                   meas_pend: 1'b0, meas_done: 1'b0, half: 1'b0,
                   dgain: rx_gain_pkg::DGAIN_RESET, bw_afc: 1'b0, waiting: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign lna_gain_choice_out = s_ff.choice;
   assign applied_lna_step_out = s_ff.step;
   assign agc_waiting_out = s_ff.waiting;
   assign signal_level_out = s_ff.level;
   assign level_measure_flag_out = s_ff.meas_done;
   assign digital_gain_out = s_ff.dgain;
   assign filter_bw_sel_out = s_ff.bw_afc;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   a_fixed_step_follow: assert property ( // [RULE1]
      (!auto_mode && !gain_choice_wr_in) |=> applied_lna_step_out == $past(s_ff.choice))
      else $error("Fixed gain choice not applied");

   a_reset_auto_choice: assert property ( // [RULE2]
      $rose(resetn_in) |-> lna_gain_choice_out == 3'h0)
      else $error("Gain choice not automatic after reset");

   a_wait_two_hits: assert property ( // [RULE3]
      (s_ff.st == rx_gain_pkg::ST_WAIT && $past(s_ff.st) == rx_gain_pkg::ST_WAIT)
      ##1 (s_ff.st == rx_gain_pkg::ST_HOLD && $past(rx_enable_in) &&
           !$past(receive_rearm_cmd_in))
      |-> $past(above_floor) && $past(s_ff.hits) == 2'h1)
      else $error("Left wait without two samples above floor");

   a_step_held: assert property ( // [RULE4]
      (s_ff.st == rx_gain_pkg::ST_HOLD && auto_mode) ##1 s_ff.st == rx_gain_pkg::ST_HOLD
      |-> $stable(applied_lna_step_out))
      else $error("Held LNA step changed");

   a_no_auto_rearm: assert property ( // [RULE5]
      (s_ff.st == rx_gain_pkg::ST_HOLD && packet_mode_in && !auto_rearm_enable_in &&
       rx_enable_in && !receive_rearm_cmd_in) |=> s_ff.st == rx_gain_pkg::ST_HOLD)
      else $error("Hold left without re-arm");

   a_rearm_delay: assert property ( // [RULE18]
      (s_ff.st == rx_gain_pkg::ST_HOLD && $rose(s_ff.st == rx_gain_pkg::ST_REARM) == 1'b0 &&
       packet_mode_in && auto_rearm_enable_in && fifo_empty_in && !s_ff.fifo_empty_q &&
       rx_enable_in && !receive_rearm_cmd_in && rearm_delay_in == 16'h0002)
      ##1 (rx_enable_in && !receive_rearm_cmd_in) [*3]
      |=> s_ff.st == rx_gain_pkg::ST_WAIT)
      else $error("Re-arm delay wrong");

   a_restart_cmd: assert property ( // [RULE7]
      (rx_enable_in && receive_rearm_cmd_in) |=> agc_waiting_out)
      else $error("Restart did not return to wait");

   a_afc_bandwidth: assert property ( // [RULE11]
      (afc_auto_in && agc_waiting_out) |-> ##1 (agc_waiting_out |-> $past(filter_bw_sel_out)))
      else $error("Correction bandwidth not used while waiting");

   a_dgain_down: assert property ( // [RULE13]
      (dgain_en && bit_tick_in && s_ff.half && amplitude_in > 8'h40 && digital_gain_out != 6'h00)
      |=> digital_gain_out == $past(digital_gain_out) - 6'h01)
      else $error("Digital gain did not step down");

   a_dgain_odd_tick: assert property ( // [RULE13]
      (bit_tick_in && !s_ff.half) |=> $stable(digital_gain_out))
      else $error("Digital gain moved on odd bit");

   a_measure_blocked: assert property ( // [RULE16]
      dgain_en |=> !level_measure_flag_out)
      else $error("Level flag set with digital loop on");

   a_level_gate: assert property ( // [RULE17]
      !$stable(signal_level_out) |-> $past(above_floor))
      else $error("Level updated below floor");

   c_acquired: cover property (s_ff.st == rx_gain_pkg::ST_WAIT ##1 s_ff.st == rx_gain_pkg::ST_HOLD);
   c_rearmed: cover property (s_ff.st == rx_gain_pkg::ST_REARM ##1 agc_waiting_out);
   c_dgain_moved: cover property (!$stable(digital_gain_out));
   c_measured: cover property ($rose(level_measure_flag_out));

endmodule : rx_gain_control

// ==== shared/rx_gain_pkg.sv ====
/*
 Constants, state types and carriers shared by the receive gain control logic.
 Assumes signal levels are signed half-dB power figures, larger meaning stronger.
*/
package rx_gain_pkg;

   // Gain choice codes
   localparam logic [2:0] CHOICE_AUTO = 3'h0;
   localparam logic [2:0] CHOICE_RESERVED = 3'h7;
   localparam logic [2:0] CHOICE_RESET = 3'h0;
   localparam logic [2:0] STEP_MAX_GAIN = 3'h1;
   localparam logic [2:0] STEP_MIN_GAIN = 3'h6;

   // Digital gain loop enable codes, reset gain and target amplitude
   localparam logic [7:0] DGAIN_CFG_LOW_INDEX = 8'h20;
   localparam logic [7:0] DGAIN_CFG_NORMAL = 8'h30;
   localparam logic [5:0] DGAIN_RESET = 6'h20;
   localparam logic [7:0] DGAIN_TARGET_AMP = 8'h40;

   // Reference terms, dB
   localparam int THERMAL_FLOOR_DB = -174;
   localparam int NOISE_FIGURE_DB = 7;
   localparam int DEMOD_MARGIN_DB = 8;
   localparam int FADE_ALLOWANCE_DB = 5;
   localparam logic signed [9:0] REF_BASE_HD =
      10'(2 * (THERMAL_FLOOR_DB + NOISE_FIGURE_DB + DEMOD_MARGIN_DB + FADE_ALLOWANCE_DB));

   // Gain switching thresholds above the reference, half-dB
   localparam logic signed [10:0] AGC_T1_OFS_HD = 11'h040;
   localparam logic signed [10:0] AGC_T_STEP_HD = 11'h00c;
   localparam int AGC_THRESHOLDS = 5;

   localparam logic [15:0] DELAY_RESET = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT,
      ST_HOLD,
      ST_REARM
   } agc_state_t;

   typedef struct packed {
      logic valid;
      logic signed [9:0] level;
   } level_sample_t;

   typedef struct packed {
      agc_state_t st;
      logic [2:0] choice;
      logic [1:0] hits;
      logic [2:0] step;
      logic [15:0] dly;
      logic fifo_empty_q;
      logic [9:0] level;
      logic meas_pend;
      logic meas_done;
      logic half;
      logic [5:0] dgain;
      logic bw_afc;
      logic waiting;
   } ctl_state_t;

endpackage : rx_gain_pkg

// ==== sim/level_source.sv ====
/*
 Model of the front-end level path: one level sample per request from the bench.
 Assumes requests arrive synchronous to clk_in.
*/
`timescale 1ns/1ps
module level_source (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic fire_in,
   input wire logic signed [9:0] level_in,
   output rx_gain_pkg::level_sample_t sample_out
);
   // Each idle cycle inverts the level shown the cycle before, so stale data never passes as a sample
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         sample_out <= '0;
      end else begin
         sample_out.valid <= fire_in;
         sample_out.level <= fire_in ? level_in : ~sample_out.level;
      end
   end
endmodule : level_source

// ==== sim/rx_gain_control_bench.sv ====
/*
 Self-checking bench for the receive gain control block.
 Assumes level_source stands in for the front end and the bench acts as host.
*/
`timescale 1ns/1ps
module rx_gain_control_bench;
   logic clk, resetn, rx_en, pkt, wr, arm, cmd, fifo_e, fire, afc, tick, meas;
   logic [2:0] choice, choice_o, step_o;
   logic [15:0] dly;
   logic signed [9:0] floor_lvl, lvl, level_o, ref_o;
   logic [19:0] bw, afc_bw;
   logic [7:0] cfg, amp;
   logic [5:0] dgain_o;
   logic waiting_o, flag_o, bwsel_o;
   rx_gain_pkg::level_sample_t smp;
   int bad_count, comparisons, cycles;

   level_source src_u (.clk_in(clk), .resetn_in(resetn), .fire_in(fire), .level_in(lvl),
      .sample_out(smp));
   rx_gain_control dut_u (.clk_in(clk), .resetn_in(resetn), .rx_enable_in(rx_en),
      .packet_mode_in(pkt), .gain_choice_wr_in(wr), .lna_gain_choice_in(choice),
      .auto_rearm_enable_in(arm), .rearm_delay_in(dly), .receive_rearm_cmd_in(cmd),
      .fifo_empty_in(fifo_e), .sample_in(smp), .signal_floor_in(floor_lvl),
      .afc_auto_in(afc), .channel_filter_bw_in(bw), .freq_correction_filter_bw_in(afc_bw),
      .digital_gain_cfg_in(cfg), .bit_tick_in(tick), .amplitude_in(amp),
      .level_measure_cmd_in(meas), .lna_gain_choice_out(choice_o),
      .applied_lna_step_out(step_o), .agc_waiting_out(waiting_o),
      .signal_level_out(level_o), .level_measure_flag_out(flag_o),
      .digital_gain_out(dgain_o), .filter_bw_sel_out(bwsel_o), .agc_reference_out(ref_o));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Hang guard: the whole run needs well under a few thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (bad_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic reset_dut();
      @(posedge clk);
      resetn <= 1'b0;
      rx_en <= 1'b0;
      cyc(16);
      resetn <= 1'b1;
      cyc(1);
   endtask : reset_dut

   task automatic send(input logic signed [9:0] v);
      @(posedge clk);
      fire <= 1'b1;
      lvl <= v;
      @(posedge clk);
      fire <= 1'b0;
      cyc(2);
   endtask : send

   task automatic wait_for(input logic v);
      int i;
      i = 0;
      while (waiting_o !== v && i < 20) begin
         cyc(1);
         i++;
      end
      check("waiting", 16'(waiting_o), 16'(v));
   endtask : wait_for

   // Steady preamble level, broken once by a sub-floor sample
   task automatic acquire(input logic signed [9:0] v, input logic [2:0] exp_step);
      @(posedge clk);
      rx_en <= 1'b1;
      wait_for(1'b1);
      check("bw_sel", 16'(bwsel_o), 16'(afc));
      send(v);
      send(-10'sd200);
      send(v);
      check("waiting", 16'(waiting_o), 16'h0001);
      send(v);
      wait_for(1'b0);
      check("step", 16'(step_o), 16'(exp_step));
      check("bw_sel", 16'(bwsel_o), 16'h0000);
   endtask : acquire

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_fixed();
      reset_dut();
      check("choice", 16'(choice_o), 16'h0000);
      check("dgain", 16'(dgain_o), 16'h0020);
      for (int c = 1; c < 8; c++) begin
         @(posedge clk);
         wr <= 1'b1;
         choice <= 3'(c);
         @(posedge clk);
         wr <= 1'b0;
         cyc(2);
         check("choice", 16'(choice_o), 16'(c));
         if (c < 7) check("step", 16'(step_o), 16'(c));
      end
      reset_dut();
   endtask : t_fixed

   // Reference near -202 half-dB at 100 kHz, -196 at the 200 kHz correction width
   task automatic t_acquire();
      logic signed [9:0] lv [3] = '{-10'sd145, -10'sd108, 10'sd500};
      logic [2:0] st [3] = '{3'h1, 3'h3, 3'h6};
      for (int i = 0; i < 3; i++) begin
         reset_dut();
         afc <= 1'(i);
         acquire(lv[i], st[i]);
      end
      check("ref", 16'(ref_o > -10'sd207 && ref_o < -10'sd197), 16'h0001);
      afc <= 1'b0;
   endtask : t_acquire

   task automatic t_rearm();
      for (int a = 0; a < 2; a++) begin
         reset_dut();
         arm <= 1'(a);
         acquire(10'sd500, 3'h6);
         @(posedge clk);
         fifo_e <= 1'b1;
         cyc(int'(dly) + 1);
         check("waiting", 16'(waiting_o), 16'h0000);
         cyc(1);
         check("waiting", 16'(waiting_o), 16'(a));
         cyc(30);
         if (a == 0) check("step", 16'(step_o), 16'h0006);
         fifo_e <= 1'b0;
      end
   endtask : t_rearm

   // Host restart in packet mode either way, then continuous, then with receiver off
   task automatic t_restart();
      for (int i = 0; i < 4; i++) begin
         reset_dut();
         arm <= 1'(i);
         pkt <= 1'(i < 2);
         acquire(10'sd500, 3'h6);
         @(posedge clk);
         if (i == 3) rx_en <= 1'b0;
         cmd <= 1'b1;
         @(posedge clk);
         cmd <= 1'b0;
         cyc(1);
         check("restart", 16'(waiting_o), 16'(i < 3));
      end
      pkt <= 1'b1;
      arm <= 1'b0;
   endtask : t_restart

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
      cyc(2);
   endtask : ticks

   task automatic t_dgain();
      for (int m = 0; m < 2; m++) begin
         reset_dut();
         pkt <= 1'(m);
         cfg <= m ? 8'h30 : 8'h20;
         amp <= 8'h10;
         ticks(4);
         check("dgain", 16'(dgain_o), 16'h0022);
         amp <= 8'h70;
         ticks(2);
         check("dgain", 16'(dgain_o), 16'h0021);
         meas <= 1'b1;
         cyc(1);
         meas <= 1'b0;
         send(10'sd20);
         check("meas_flag", 16'(flag_o), 16'h0000);
         cfg <= 8'h00;
         ticks(4);
         check("dgain", 16'(dgain_o), 16'h0021);
      end
      meas <= 1'b1;
      cyc(1);
      meas <= 1'b0;
      send(10'sd30);
      check("meas_flag", 16'(flag_o), 16'h0001);
      check("level", 16'(level_o), 16'(10'sd30));
      send(-10'sd160);
      check("level", 16'(level_o), 16'(10'sd30));
   endtask : t_dgain

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {resetn, rx_en, wr, arm, cmd, fifo_e, fire, afc, tick, meas} = '0;
      pkt = 1'b1;
      choice = 3'h0;
      // Same delay as the re-arm assertion watches
      dly = 16'h0002;
      floor_lvl = -10'sd150;
      lvl = 10'h000;
      bw = 20'd100000;
      afc_bw = 20'd200000;
      cfg = 8'h00;
      amp = 8'h40;
      t_fixed();
      t_acquire();
      t_rearm();
      t_restart();
      t_dgain();
      stop_test();
   end
endmodule : rx_gain_control_bench
